/* include/tlis_pkg.sv */
// Constants, types and register map of the two-level interrupt sequencer
package tlis_pkg;

  // Number of system interrupts per variant, sources per interrupt, external pins
  localparam int NUM_IRQ_FULL    = 10;
  localparam int NUM_IRQ_REDUCED = 6;
  localparam int SRC_PER_IRQ     = 4;
  localparam int NUM_EXT         = 3;

  // System interrupt ranks, rank 0 is the highest
  localparam int IRQ_RESET     = 0;
  localparam int IRQ_EXT_ONE   = 1;
  localparam int IRQ_EXT_THREE = 3;
  localparam int IRQ_TIMER_ONE = 5;

  // Vector table: rank 0 uses the top pair, each rank two bytes lower
  localparam logic [15:0] VEC_TOP_HI = 16'h7FFE;

  // CPU status register
  localparam logic [7:0] ST_CLEARED  = 8'h00;
  localparam int         ST_IE1_BIT  = 2;
  localparam int         ST_IE2_BIT  = 3;

  // Stack lives in page zero
  localparam logic [7:0] STACK_PAGE = 8'h00;

  // Least entry latency in clock cycles
  localparam int ENTRY_MIN_CYC = 15;

  // Low-power modes
  localparam logic [1:0] LPM_RUN     = 2'b00;
  localparam logic [1:0] LPM_STANDBY = 2'b01;
  localparam logic [1:0] LPM_HALT    = 2'b10;

  // Wake capability per rank
  localparam logic [9:0] WAKE_FULL_MASK    = 10'h00F;
  localparam logic [9:0] WAKE_STANDBY_MASK = 10'h02F;

  // APB register byte addresses
  localparam logic [11:0] ADDR_LEVEL    = 12'h000;
  localparam logic [11:0] ADDR_LOCK     = 12'h004;
  localparam logic [11:0] ADDR_EXT_CTRL = 12'h008;
  localparam logic [11:0] ADDR_STATUS   = 12'h00C;

  // External control byte layout, one byte per pin
  localparam int EXT_ENABLE_BIT   = 0;
  localparam int EXT_POLARITY_BIT = 2;
  localparam int EXT_NMI_BIT      = 3;
  localparam int EXT_PIN_BIT      = 6;
  localparam int EXT_FLAG_BIT     = 7;

  // Status register layout
  localparam int STAT_LAST_LSB  = 10;
  localparam int STAT_POWER_BIT = 16;
  localparam int STAT_BUSY_BIT  = 17;

  // Reset values
  localparam logic [9:0] LEVEL_RESET = 10'h3FF;
  localparam logic [9:0] LOCK_RESET  = 10'h000;

  typedef enum logic [3:0] {
    SQ_IDLE, SQ_PUSH_ST, SQ_CLR_ST, SQ_PUSH_PCH, SQ_VEC_HI, SQ_PUSH_PCL,
    SQ_VEC_LO, SQ_RESUME, SQ_POP_PCL, SQ_POP_PCH, SQ_POP_ST, SQ_RETURN
  } tlis_state_type;

  typedef struct packed {
    logic        nmi;
    logic        polarity;
    logic        enable;
  } tlis_ext_cfg_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } tlis_mem_req_type;

endpackage

/* src/tlis_sequencer.sv */
// Two-level interrupt arbiter and context-switch sequencer with APB registers
//
// Operation
// RULE_01: Two priority levels; level one always beats level two.
// RULE_02: Each level has its own global enable in the status register.
// RULE_03: Level assignment writable anytime, except privilege-locked entries.
// RULE_04: All enabled level one requests served first; fixed order inside a level.
// RULE_05: Each system interrupt has a two-byte vector, fetched high then low.
// RULE_06: Ranks one to ten map to descending vector pairs from the top.
// RULE_07: Full variant has ten system interrupts, reduced variant the first six.
// RULE_08: Each source has its own local enable bit.
// RULE_09: Each source flag is readable by software.
// RULE_10: A source is acknowledged only when flag and enables are set; with the NMI bit set, external pin zero needs only its flag.
// RULE_11: Service software clears source flags before returning.
// RULE_12: Arbitrate at each opcode fetch; discard opcode and start switch.
// RULE_13: First step: increment stack pointer and push the status register.
// RULE_14: Then load status with zero and identify the requester.
// RULE_15: Rewind PC, push high byte, load vector high, push low, load low.
// RULE_16: Return pops status and program counter and resumes.
// RULE_17: Entry latency at least fifteen cycles.
// RULE_18: Wait states lengthen entry latency cycle for cycle.
// RULE_19: External pins pass a two-cycle synchronizer before arbitration.
// RULE_20: Full-wake interrupts release both standby and halt.
// RULE_21: Timer one interrupt releases standby only.
// RULE_22: External flag sets on selected edge; request needs local and level enables; pin zero with NMI set needs neither.
// RULE_23: System request is OR of source flags ANDed with local enables.
// RULE_24: Reset-class requests bypass global enables and keep top priority.
`timescale 1ns/1ps
`default_nettype none

module tlis_sequencer #(
  parameter int NUM_IRQ = tlis_pkg::NUM_IRQ_FULL,
  parameter int SRCS    = tlis_pkg::SRC_PER_IRQ
) (
  input  wire logic                      REF_CLK,
  input  wire logic                      RESET_N,
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [11:0]               PADDR,
  input  wire logic [31:0]               PWDATA,
  output logic      [31:0]               PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  input  wire logic [tlis_pkg::NUM_EXT-1:0] EXT_IRQ_PIN,
  input  wire logic                      RESET_CLASS_REQ,
  input  wire logic [NUM_IRQ*SRCS-1:0]   PERIPH_FLAG,
  input  wire logic [NUM_IRQ*SRCS-1:0]   PERIPH_EN,
  input  wire logic                      PRIV_PROTECT,
  input  wire logic                      CPU_FETCH_DONE,
  input  wire logic                      CPU_RETURN,
  input  wire logic [15:0]               CPU_PC,
  input  wire logic [7:0]                CPU_ST,
  input  wire logic [7:0]                CPU_SP,
  input  wire logic [1:0]                LPM_MODE,
  output logic                           CPU_DISCARD,
  output logic                           CPU_HOLD,
  output logic                           CPU_ST_WE,
  output logic      [7:0]                CPU_ST_DATA,
  output logic                           CPU_SP_WE,
  output logic      [7:0]                CPU_SP_DATA,
  output logic      [1:0]                CPU_PC_WE,
  output logic      [15:0]               CPU_PC_DATA,
  output logic                           CPU_RESUME,
  output tlis_pkg::tlis_mem_req_type     MEM_REQ,
  input  wire logic                      MEM_ACK,
  input  wire logic [7:0]                MEM_RDATA,
  output logic                           WAKE
);

  localparam logic [9:0] IMPL_MASK = 10'((1 << NUM_IRQ) - 1);

  tlis_pkg::tlis_state_type               state_r;
  tlis_pkg::tlis_ext_cfg_type [tlis_pkg::NUM_EXT-1:0] ext_cfg_r;
  logic [tlis_pkg::NUM_EXT-1:0]           ext_sync1_r;
  logic [tlis_pkg::NUM_EXT-1:0]           ext_sync2_r;
  logic [tlis_pkg::NUM_EXT-1:0]           ext_prev_r;
  logic [tlis_pkg::NUM_EXT-1:0]           ext_flag_r;
  logic [tlis_pkg::NUM_EXT-1:0]           ext_edge;
  logic [tlis_pkg::NUM_EXT-1:0]           ext_flag_clr;
  logic [9:0]                             level_one_r;
  logic [9:0]                             lock_r;
  logic                                   power_on_flag_r;
  logic [3:0]                             last_rank_r;
  logic [3:0]                             rank_r;
  logic [7:0]                             sp_r;
  logic [15:0]                            pc_save_r;
  logic [7:0]                             st_save_r;
  logic [15:0]                            pc_new_r;
  logic [7:0]                             entry_cnt_r;
  logic [9:0]                             sys_req;
  logic [9:0]                             eligible;
  logic                                   take;
  logic [3:0]                             win_rank;
  logic                                   level_one_global_enable;
  logic                                   level_two_global_enable;
  logic                                   wr_en;
  logic                                   rd_en;
  logic [15:0]                            vec_hi_addr;
  logic                                   mem_need;
  logic                                   mem_write;
  logic [15:0]                            mem_addr;
  logic [7:0]                             mem_wdata;
  logic                                   step_done;
  logic [31:0]                            rd_data;
  logic                                   rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, answers in the second access cycle

  // Writes land at the edge that completes the transfer
  assign wr_en = PSEL && PENABLE && PWRITE && PREADY;
  assign rd_en = PSEL && PENABLE && !PWRITE && !PREADY;

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    case (PADDR)
      tlis_pkg::ADDR_LEVEL:    rd_data[9:0] = level_one_r;
      tlis_pkg::ADDR_LOCK:     rd_data[9:0] = lock_r;
      tlis_pkg::ADDR_EXT_CTRL: begin
        for (int k = 0; k < tlis_pkg::NUM_EXT; k++) begin
          rd_data[8*k+tlis_pkg::EXT_ENABLE_BIT]   = ext_cfg_r[k].enable;
          rd_data[8*k+tlis_pkg::EXT_POLARITY_BIT] = ext_cfg_r[k].polarity;
          rd_data[8*k+tlis_pkg::EXT_NMI_BIT]      = ext_cfg_r[k].nmi;
          rd_data[8*k+tlis_pkg::EXT_PIN_BIT]      = ext_sync2_r[k];
          rd_data[8*k+tlis_pkg::EXT_FLAG_BIT]     = ext_flag_r[k]; // RULE_09
        end
      end
      tlis_pkg::ADDR_STATUS: begin
        rd_data[9:0] = sys_req; // RULE_09
        rd_data[tlis_pkg::STAT_LAST_LSB +: 4] = last_rank_r;
        rd_data[tlis_pkg::STAT_POWER_BIT]     = power_on_flag_r;
        rd_data[tlis_pkg::STAT_BUSY_BIT]      = (state_r != tlis_pkg::SQ_IDLE);
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !rd_hit;
      PRDATA  <= rd_en ? rd_data : 32'h0000_0000;
    end
  end

  // Level assignment; locked entries resist change while protected
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      level_one_r <= tlis_pkg::LEVEL_RESET;
      lock_r      <= tlis_pkg::LOCK_RESET;
    end else if (wr_en) begin
      if (PADDR == tlis_pkg::ADDR_LEVEL) begin
        level_one_r <= PRIV_PROTECT ? ((PWDATA[9:0] & ~lock_r) | (level_one_r & lock_r))
                                    : PWDATA[9:0]; // RULE_03
      end
      if (PADDR == tlis_pkg::ADDR_LOCK && !PRIV_PROTECT) begin
        lock_r <= PWDATA[9:0]; // RULE_03
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      ext_cfg_r <= '0;
    end else if (wr_en && PADDR == tlis_pkg::ADDR_EXT_CTRL) begin
      for (int k = 0; k < tlis_pkg::NUM_EXT; k++) begin
        ext_cfg_r[k].enable   <= PWDATA[8*k+tlis_pkg::EXT_ENABLE_BIT]; // RULE_08
        ext_cfg_r[k].polarity <= PWDATA[8*k+tlis_pkg::EXT_POLARITY_BIT];
        if (k == 0 && !PRIV_PROTECT) begin
          ext_cfg_r[k].nmi <= PWDATA[tlis_pkg::EXT_NMI_BIT]; // RULE_03
        end
      end
    end
  end

  // Power-on flag is set by reset and cleared by writing zero
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      power_on_flag_r <= 1'b1;
    end else if (wr_en && PADDR == tlis_pkg::ADDR_STATUS && !PWDATA[tlis_pkg::STAT_POWER_BIT]) begin
      power_on_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External pins: synchronizer, edge detect, sticky flag

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      ext_sync1_r <= '0;
      ext_sync2_r <= '0;
      ext_prev_r  <= '0;
    end else begin
      ext_sync1_r <= EXT_IRQ_PIN; // RULE_19
      ext_sync2_r <= ext_sync1_r; // RULE_19
      ext_prev_r  <= ext_sync2_r;
    end
  end

  always_comb begin
    for (int k = 0; k < tlis_pkg::NUM_EXT; k++) begin
      ext_edge[k] = ext_cfg_r[k].polarity ? (ext_sync2_r[k] && !ext_prev_r[k])
                                          : (!ext_sync2_r[k] && ext_prev_r[k]); // RULE_22
      ext_flag_clr[k] = wr_en && PADDR == tlis_pkg::ADDR_EXT_CTRL
                        && !PWDATA[8*k+tlis_pkg::EXT_FLAG_BIT];
    end
  end

  // A new edge wins over a clear in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      ext_flag_r <= '0;
    end else begin
      ext_flag_r <= ext_edge | (ext_flag_r & ~ext_flag_clr); // RULE_22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request formation and two-level arbitration

  assign level_one_global_enable = CPU_ST[tlis_pkg::ST_IE1_BIT];
  assign level_two_global_enable = CPU_ST[tlis_pkg::ST_IE2_BIT];

  always_comb begin
    sys_req = '0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      for (int s = 0; s < SRCS; s++) begin
        sys_req[i] = sys_req[i] | (PERIPH_FLAG[i*SRCS+s] & PERIPH_EN[i*SRCS+s]); // RULE_23 RULE_10
      end
    end
    sys_req[tlis_pkg::IRQ_RESET] = RESET_CLASS_REQ;
    for (int k = 0; k < tlis_pkg::NUM_EXT; k++) begin
      sys_req[tlis_pkg::IRQ_EXT_ONE+k] = ext_flag_r[k] && ext_cfg_r[k].enable; // RULE_22
    end
    sys_req = sys_req & IMPL_MASK; // RULE_07
  end

  always_comb begin
    for (int i = 0; i < 10; i++) begin
      eligible[i] = sys_req[i] && (level_one_r[i] ? level_one_global_enable
                                                  : level_two_global_enable); // RULE_02 RULE_10
    end
    eligible[tlis_pkg::IRQ_RESET] = sys_req[tlis_pkg::IRQ_RESET]; // RULE_24
    if (ext_cfg_r[0].nmi) begin
      eligible[tlis_pkg::IRQ_EXT_ONE] = ext_flag_r[0];
    end
  end

  // Highest level first, then lowest rank; reset rank always wins
  always_comb begin
    win_rank = 4'd0;
    take     = 1'b0;
    for (int i = 9; i >= 0; i--) begin
      if (eligible[i] && !level_one_r[i]) begin
        win_rank = 4'(i); // RULE_04
        take     = 1'b1;
      end
    end
    for (int i = 9; i >= 0; i--) begin
      if (eligible[i] && level_one_r[i]) begin
        win_rank = 4'(i); // RULE_01 RULE_04
        take     = 1'b1;
      end
    end
    if (eligible[tlis_pkg::IRQ_RESET]) begin
      win_rank = 4'(tlis_pkg::IRQ_RESET); // RULE_24
    end
  end

  assign vec_hi_addr = tlis_pkg::VEC_TOP_HI - {11'h000, rank_r, 1'b0}; // RULE_06

  ////////////////////////////////////////////////////////////////////////////
  // Context switch and return sequencer

  always_comb begin
    mem_need  = 1'b1;
    mem_write = 1'b1;
    mem_addr  = {tlis_pkg::STACK_PAGE, sp_r};
    mem_wdata = st_save_r;
    case (state_r)
      tlis_pkg::SQ_PUSH_ST:  mem_wdata = st_save_r; // RULE_13
      tlis_pkg::SQ_PUSH_PCH: mem_wdata = pc_save_r[15:8]; // RULE_15
      tlis_pkg::SQ_PUSH_PCL: mem_wdata = pc_save_r[7:0]; // RULE_15
      tlis_pkg::SQ_VEC_HI: begin
        mem_write = 1'b0;
        mem_addr  = vec_hi_addr; // RULE_05
      end
      tlis_pkg::SQ_VEC_LO: begin
        mem_write = 1'b0;
        mem_addr  = vec_hi_addr + 16'h0001; // RULE_05
      end
      tlis_pkg::SQ_POP_PCL, tlis_pkg::SQ_POP_PCH, tlis_pkg::SQ_POP_ST: mem_write = 1'b0; // RULE_16
      default: mem_need = 1'b0;
    endcase
  end

  // Memory steps wait for the acknowledge, so wait states add cycles
  assign step_done = MEM_REQ.valid && MEM_ACK; // RULE_18

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      MEM_REQ <= '0;
    end else if (step_done) begin
      MEM_REQ.valid <= 1'b0;
    end else if (mem_need && !MEM_REQ.valid) begin
      MEM_REQ.valid <= 1'b1;
      MEM_REQ.write <= mem_write;
      MEM_REQ.addr  <= mem_addr;
      MEM_REQ.wdata <= mem_wdata;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      state_r <= tlis_pkg::SQ_IDLE;
    end else begin
      case (state_r)
        tlis_pkg::SQ_IDLE: begin
          if (CPU_FETCH_DONE && take) begin
            state_r <= tlis_pkg::SQ_PUSH_ST; // RULE_12
          end else if (CPU_RETURN) begin
            state_r <= tlis_pkg::SQ_POP_PCL; // RULE_16
          end
        end
        tlis_pkg::SQ_PUSH_ST:  if (step_done) state_r <= tlis_pkg::SQ_CLR_ST;
        tlis_pkg::SQ_CLR_ST:   state_r <= tlis_pkg::SQ_PUSH_PCH;
        tlis_pkg::SQ_PUSH_PCH: if (step_done) state_r <= tlis_pkg::SQ_VEC_HI;
        tlis_pkg::SQ_VEC_HI:   if (step_done) state_r <= tlis_pkg::SQ_PUSH_PCL;
        tlis_pkg::SQ_PUSH_PCL: if (step_done) state_r <= tlis_pkg::SQ_VEC_LO;
        tlis_pkg::SQ_VEC_LO:   if (step_done) state_r <= tlis_pkg::SQ_RESUME;
        tlis_pkg::SQ_RESUME: begin
          if (entry_cnt_r >= 8'(tlis_pkg::ENTRY_MIN_CYC - 1)) begin
            state_r <= tlis_pkg::SQ_IDLE; // RULE_17
          end
        end
        tlis_pkg::SQ_POP_PCL:  if (step_done) state_r <= tlis_pkg::SQ_POP_PCH;
        tlis_pkg::SQ_POP_PCH:  if (step_done) state_r <= tlis_pkg::SQ_POP_ST;
        tlis_pkg::SQ_POP_ST:   if (step_done) state_r <= tlis_pkg::SQ_RETURN;
        tlis_pkg::SQ_RETURN:   state_r <= tlis_pkg::SQ_IDLE;
        default:               state_r <= tlis_pkg::SQ_IDLE;
      endcase
    end
  end

  // Saved context, stack pointer tracking and gathered vector
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      sp_r        <= 8'h00;
      pc_save_r   <= 16'h0000;
      st_save_r   <= 8'h00;
      pc_new_r    <= 16'h0000;
      rank_r      <= 4'h0;
      last_rank_r <= 4'h0;
      entry_cnt_r <= 8'h00;
    end else begin
      // Wait cycles are not counted, so they add on top of the floor
      if (entry_cnt_r != 8'hFF && !(MEM_REQ.valid && !MEM_ACK)) begin
        entry_cnt_r <= entry_cnt_r + 8'h01; // RULE_18
      end
      case (state_r)
        tlis_pkg::SQ_IDLE: begin
          entry_cnt_r <= 8'h00;
          if (CPU_FETCH_DONE && take) begin
            sp_r        <= CPU_SP + 8'h01; // RULE_13
            pc_save_r   <= CPU_PC; // RULE_12 RULE_15
            st_save_r   <= CPU_ST; // RULE_13
            rank_r      <= win_rank; // RULE_14
            last_rank_r <= win_rank;
          end else if (CPU_RETURN) begin
            sp_r <= CPU_SP;
          end
        end
        tlis_pkg::SQ_PUSH_ST, tlis_pkg::SQ_PUSH_PCH: begin
          if (step_done) begin
            sp_r <= sp_r + 8'h01; // RULE_15
          end
        end
        tlis_pkg::SQ_VEC_HI: begin
          if (step_done) begin
            pc_new_r[15:8] <= MEM_RDATA; // RULE_15
          end
        end
        tlis_pkg::SQ_VEC_LO: begin
          if (step_done) begin
            pc_new_r[7:0] <= MEM_RDATA; // RULE_15
          end
        end
        tlis_pkg::SQ_POP_PCL: begin
          if (step_done) begin
            pc_new_r[7:0] <= MEM_RDATA; // RULE_16
            sp_r          <= sp_r - 8'h01;
          end
        end
        tlis_pkg::SQ_POP_PCH: begin
          if (step_done) begin
            pc_new_r[15:8] <= MEM_RDATA; // RULE_16
            sp_r           <= sp_r - 8'h01;
          end
        end
        tlis_pkg::SQ_POP_ST: begin
          if (step_done) begin
            st_save_r <= MEM_RDATA; // RULE_16
            sp_r      <= sp_r - 8'h01;
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU register update strobes

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      CPU_DISCARD <= 1'b0;
      CPU_HOLD    <= 1'b0;
      CPU_ST_WE   <= 1'b0;
      CPU_ST_DATA <= 8'h00;
      CPU_SP_WE   <= 1'b0;
      CPU_SP_DATA <= 8'h00;
      CPU_PC_WE   <= 2'b00;
      CPU_PC_DATA <= 16'h0000;
      CPU_RESUME  <= 1'b0;
    end else begin
      CPU_DISCARD <= state_r == tlis_pkg::SQ_IDLE && CPU_FETCH_DONE && take; // RULE_12
      CPU_HOLD    <= !(state_r == tlis_pkg::SQ_IDLE && !(CPU_FETCH_DONE && take) && !CPU_RETURN)
                     && !(state_r == tlis_pkg::SQ_RESUME && entry_cnt_r >= 8'(tlis_pkg::ENTRY_MIN_CYC - 1))
                     && state_r != tlis_pkg::SQ_RETURN;
      CPU_ST_WE   <= 1'b0;
      CPU_SP_WE   <= 1'b0;
      CPU_PC_WE   <= 2'b00;
      CPU_RESUME  <= 1'b0;
      case (state_r)
        tlis_pkg::SQ_IDLE: begin
          if (CPU_FETCH_DONE && take) begin
            CPU_PC_WE   <= 2'b11;
            CPU_PC_DATA <= CPU_PC; // RULE_15
          end
        end
        tlis_pkg::SQ_CLR_ST: begin
          CPU_ST_WE   <= 1'b1;
          CPU_ST_DATA <= tlis_pkg::ST_CLEARED; // RULE_14
        end
        tlis_pkg::SQ_VEC_HI: begin
          if (step_done) begin
            CPU_PC_WE   <= 2'b10;
            CPU_PC_DATA <= {MEM_RDATA, 8'h00}; // RULE_15
          end
        end
        tlis_pkg::SQ_VEC_LO: begin
          if (step_done) begin
            CPU_PC_WE   <= 2'b01;
            CPU_PC_DATA <= {8'h00, MEM_RDATA}; // RULE_15
            CPU_SP_WE   <= 1'b1;
            CPU_SP_DATA <= sp_r;
          end
        end
        tlis_pkg::SQ_RESUME: begin
          if (entry_cnt_r >= 8'(tlis_pkg::ENTRY_MIN_CYC - 1)) begin
            CPU_RESUME <= 1'b1; // RULE_15 RULE_17
          end
        end
        tlis_pkg::SQ_RETURN: begin
          CPU_ST_WE   <= 1'b1;
          CPU_ST_DATA <= st_save_r; // RULE_16
          CPU_SP_WE   <= 1'b1;
          CPU_SP_DATA <= sp_r;
          CPU_PC_WE   <= 2'b11;
          CPU_PC_DATA <= pc_new_r;
          CPU_RESUME  <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up from low-power modes

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      WAKE <= 1'b0;
    end else begin
      case (LPM_MODE)
        tlis_pkg::LPM_HALT:    WAKE <= |(eligible & tlis_pkg::WAKE_FULL_MASK); // RULE_20
        tlis_pkg::LPM_STANDBY: WAKE <= |(eligible & tlis_pkg::WAKE_STANDBY_MASK); // RULE_20 RULE_21
        default:               WAKE <= 1'b0;
      endcase
    end
  end

endmodule

`default_nettype wire

/* tb/tb_top.sv */
// Directed bench for the interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0, rn = 1'b0, sel = 1'b0, en = 1'b0, wr = 1'b0, fd = 1'b0, rt = 1'b0, rdy, err, res, ack;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0000_0000, rd;
  logic [39:0] fl = '0, le = '0;
  logic [15:0] pcw, pd;
  logic [7:0]  st = 8'h04, sp = 8'h40, md;
  logic [3:0]  slw = 4'h0;
  logic [2:0]  pin = 3'h0;
  logic [1:0]  lpm = 2'h0;
  logic        wk;
  logic [32:0] r;
  logic [1:0]  pwe;
  int          n_errors = 0, checks_done = 0, lat;
  tlis_pkg::tlis_mem_req_type mq;
  always #12.5 clk = ~clk;
  tlis_sequencer DUT (.REF_CLK(clk), .RESET_N(rn), .PSEL(sel), .PENABLE(en), .PWRITE(wr), .PADDR(adr),
    .PWDATA(wd), .PRDATA(rd), .PREADY(rdy), .PSLVERR(err), .EXT_IRQ_PIN(pin), .RESET_CLASS_REQ(1'b0),
    .PERIPH_FLAG(fl), .PERIPH_EN(le), .PRIV_PROTECT(1'b0), .CPU_FETCH_DONE(fd), .CPU_RETURN(rt), .CPU_PC(16'h1234),
    .CPU_ST(st), .CPU_SP(sp), .LPM_MODE(lpm), .CPU_DISCARD(), .CPU_HOLD(), .CPU_ST_WE(), .CPU_ST_DATA(),
    .CPU_SP_WE(), .CPU_SP_DATA(), .CPU_PC_WE(pwe), .CPU_PC_DATA(pd), .CPU_RESUME(res), .MEM_REQ(mq),
    .MEM_ACK(ack), .MEM_RDATA(md), .WAKE(wk));
  tlis_mem_model u_mem (.clk(clk), .req(mq), .slow(slw), .ack(ack), .rdata(md));
  always @(posedge clk) pcw <= {pwe[1] ? pd[15:8] : pcw[15:8], pwe[0] ? pd[7:0] : pcw[7:0]};
  task chk(input logic [32:0] g, e);
    checks_done++;
    if (g !== e) n_errors++;
    if (g !== e) $display("[ERR] %0t got %h exp %h", $time, g, e);
  endtask
  task print_verdict;
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Request held until the edge that samples ready high; answer taken there
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    {sel, en, wr, adr, wd} <= {2'b10, w, a, d};
    @(posedge clk) en <= 1'b1;
    for (k = 0; k < 9 && rdy !== 1'b1; k++) @(posedge clk);
    chk(rdy, 1'b1);
    if (rdy !== 1'b1) print_verdict;
    r = {err, rd};
    {sel, en} <= 2'b00;
    @(posedge clk);
  endtask
  // Fetch or return pulse, then count cycles up to the resume strobe
  task go(input logic f);
    {fd, rt} <= {f, !f};
    @(posedge clk) {fd, rt} <= 2'b00;
    for (lat = 0; lat < 300 && res !== 1'b1; lat++) @(negedge clk);
    chk(res, 1'b1);
    if (res !== 1'b1) print_verdict;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rn <= 1'b1;
    @(posedge clk);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(r, 33'h0_0000_03FF);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(r, 33'h1_0000_0000);
    {fl[20], le[20]} <= 2'b11;
    go(1'b1);
    chk(pcw, 16'h5150);
    chk(lat >= 15, 1'b1);
    {fl[20], sp} <= {1'b0, 8'h43};
    go(1'b0);
    chk(pcw, 16'h1234);
    apb(1'b1, 12'h000, 32'h0000_03DF);
    {fl[20], fl[28], le[28], st, sp, slw} <= {3'b111, 8'h0C, 8'h40, 4'h3};
    go(1'b1);
    chk(pcw, 16'h5554);
    chk(lat >= 30, 1'b1);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(r[13:0], 14'h1CA0);
    lpm <= 2'h1;
    repeat (2) @(posedge clk);
    chk(wk, 1'b1);
    lpm <= 2'h2;
    repeat (2) @(posedge clk);
    chk(wk, 1'b0);
    apb(1'b1, 12'h008, 32'h0000_0085);
    pin <= 3'h1;
    repeat (4) @(posedge clk);
    chk(wk, 1'b0);
    @(posedge clk);
    chk(wk, 1'b1);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(r, 33'h0_0000_00C5);
    print_verdict;
  end
endmodule
`default_nettype wire

/* tb/tlis_checker.sv */
// Port assertions for the interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module tlis_checker (
  input wire logic        REF_CLK,
  input wire logic        RESET_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [15:0] CPU_PC,
  input wire logic        CPU_DISCARD,
  input wire logic        CPU_HOLD,
  input wire logic [1:0]  CPU_PC_WE,
  input wire logic [15:0] CPU_PC_DATA,
  input wire logic        CPU_RESUME);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  a_ready_follows: assert property (PSEL && $rose(PENABLE) |=> PREADY) else $error("late ready");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
  a_bad_addr: assert property (PREADY && PADDR > 12'h00C |-> PSLVERR && PRDATA == 32'h0000_0000) else $error("bad addr");
  a_pc_rewind: assert property (CPU_DISCARD |-> CPU_PC_WE == 2'h3 && CPU_PC_DATA == $past(CPU_PC)) else $error("rewind");
  a_hold_set: assert property (CPU_DISCARD |-> CPU_HOLD) else $error("no hold");
  a_entry_min: assert property (CPU_DISCARD |-> !CPU_RESUME [*8] ##1 !CPU_RESUME [*6]) else $error("early");
  a_entry_max: assert property (CPU_DISCARD |-> ##[14:400] CPU_RESUME) else $error("no resume");
  a_hold_drop: assert property (CPU_RESUME |-> !CPU_HOLD) else $error("hold kept");
endmodule
bind tlis_sequencer tlis_checker u_chk (.REF_CLK, .RESET_N, .PSEL, .PENABLE, .PADDR, .PRDATA, .PREADY, .PSLVERR,
  .CPU_PC, .CPU_DISCARD, .CPU_HOLD, .CPU_PC_WE, .CPU_PC_DATA, .CPU_RESUME);
`default_nettype wire

/* tb/tlis_mem_model.sv */
// Memory partner: stack page and vector bytes, optional wait states
`timescale 1ns/1ps
`default_nettype none
module tlis_mem_model (
  input  wire logic                       clk,
  input  wire tlis_pkg::tlis_mem_req_type req,
  input  wire logic [3:0]                 slow,
  output logic                            ack,
  output logic [7:0]                      rdata);
  logic [7:0] last = 8'h00, mem [256];
  logic [3:0] cnt = 4'h0;
  // Unwritten bytes read as low address byte xor A5
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
  assign ack = req.valid && cnt >= slow;
  assign rdata = ack ? mem[req.addr[7:0]] : ~last;
  always @(posedge clk) begin
    cnt <= ack ? 4'h0 : cnt + 4'(req.valid);
    if (ack) last <= rdata;
    if (ack && req.write) mem[req.addr[7:0]] <= req.wdata;
  end
endmodule
`default_nettype wire
